// [verilog/bfci_map.vh]
// bfci_map.vh: constants for the banked flash host controller
// assumes: included by bare name from the controller modules
`ifndef BFCI_MAP_VH
`define BFCI_MAP_VH
// geometry
`define BFCI_ADDR_W      23
`define BFCI_DATA_W      16
`define BFCI_PAGE_W      3
`define BFCI_BANK_W      2
// status bit positions on the word data lines
`define BFCI_POLL_BIT    7
`define BFCI_TOGGLE_BIT  6
// command codes (standard single-supply command set)
`define BFCI_UNLK_A1     23'h000555
`define BFCI_UNLK_A2     23'h0002aa
`define BFCI_UNLK_D1     16'h00aa
`define BFCI_UNLK_D2     16'h0055
`define BFCI_CMD_PROG    16'h00a0
`define BFCI_CMD_ERASE   16'h0080
`define BFCI_CMD_SECT    16'h0030
`define BFCI_CMD_SUSP    16'h00b0
`define BFCI_CMD_RESUME  16'h0030
`define BFCI_CMD_BYPASS  16'h0020
`define BFCI_CMD_BYPRST  16'h0090
`define BFCI_CMD_BYPRS2  16'h0000
`define BFCI_CMD_RESET   16'h00f0
// user operation codes
`define BFCI_OP_READ     3'h0
`define BFCI_OP_PROG     3'h1
`define BFCI_OP_ERASE    3'h2
`define BFCI_OP_SUSP     3'h3
`define BFCI_OP_RESUME   3'h4
`define BFCI_OP_BYPON    3'h5
`define BFCI_OP_BYPOFF   3'h6
`define BFCI_OP_RESET    3'h7
// bus cycle timing in ns at the 20 MHz clock
`define BFCI_CLK_NS      50
`define BFCI_T_RAND_NS   70
`define BFCI_T_PAGE_NS   30
`define BFCI_T_WP_NS     50
`define BFCI_T_WH_NS     50
`endif

// [verilog/bfci_cycle.v]
// bfci_cycle.v: one asynchronous bus cycle (read or write) on the flash pins
// assumes: flash pins are driven straight from these registers; read data
//          is sampled only after the access time has elapsed
`timescale 1ns/1ps
`include "bfci_map.vh"
module bfci_cycle #(
	parameter AW = `BFCI_ADDR_W,
	parameter DW = `BFCI_DATA_W
) (
	// clock and reset
	input  wire          clk_i,
	input  wire          nrst_i,
	// cycle request
	input  wire          go_i,
	input  wire          wr_i,
	input  wire          fast_i,
	input  wire [AW-1:0] addr_i,
	input  wire [DW-1:0] wdata_i,
	output wire          busy_o,
	output reg           done_o,
	output reg  [DW-1:0] rdata_o,
	// flash pins
	output reg  [AW-1:0] flash_addr_o,
	output reg           flash_select_n_o,
	output reg           flash_wr_n_o,
	output reg           flash_oe_n_o,
	output reg  [DW-1:0] word_data_lines_o,
	output reg           word_data_lines_oe_o,
	input  wire [DW-1:0] word_data_sync_i
);
	// least times round up to whole cycles
	localparam integer RD_N = (`BFCI_T_RAND_NS + `BFCI_CLK_NS - 1)
		/ `BFCI_CLK_NS + 2;
	localparam integer PG_N = (`BFCI_T_PAGE_NS + `BFCI_CLK_NS - 1)
		/ `BFCI_CLK_NS + 2;
	localparam integer WP_N = (`BFCI_T_WP_NS + `BFCI_CLK_NS - 1)
		/ `BFCI_CLK_NS;
	localparam integer WH_N = (`BFCI_T_WH_NS + `BFCI_CLK_NS - 1)
		/ `BFCI_CLK_NS;
	// counts cut to the counter width on purpose
	localparam [3:0] RD_CYC = RD_N[3:0];
	localparam [3:0] PG_CYC = PG_N[3:0];
	localparam [3:0] WP_CYC = WP_N[3:0];
	localparam [3:0] WH_CYC = WH_N[3:0];
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_ACT  = 2'h1;
	localparam [1:0] S_HOLD = 2'h2;
	reg [1:0] state_ff;
	reg [3:0] cnt_ff;
	reg       wr_ff;
	assign busy_o = (state_ff != S_IDLE);
	////////////////////////////////////////////////////////////////////
	// cycle sequencer; read adds two cycles for the pin synchroniser
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_ff             <= S_IDLE;
			cnt_ff               <= 4'h0;
			wr_ff                <= 1'b0;
			done_o               <= 1'b0;
			rdata_o              <= {DW{1'b0}};
			flash_addr_o         <= {AW{1'b0}};
			flash_select_n_o     <= 1'b1;
			flash_wr_n_o         <= 1'b1;
			flash_oe_n_o         <= 1'b1;
			word_data_lines_o    <= {DW{1'b0}};
			word_data_lines_oe_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_ff)
			S_IDLE: begin
				if (go_i) begin
					wr_ff            <= wr_i;
					flash_addr_o     <= addr_i;
					flash_select_n_o <= 1'b0;
					if (wr_i) begin
						// strobe off while we drive the bus
						flash_oe_n_o         <= 1'b1;
						flash_wr_n_o         <= 1'b0;
						word_data_lines_o    <= wdata_i;
						word_data_lines_oe_o <= 1'b1;
						cnt_ff               <= WP_CYC;
					end else begin
						flash_oe_n_o <= 1'b0;
						// same page: shorter wait
						cnt_ff <= fast_i ? PG_CYC : RD_CYC;
					end
					state_ff <= S_ACT;
				end
			end
			S_ACT: begin
				if (cnt_ff > 4'h1) begin
					cnt_ff <= cnt_ff - 4'h1;
				end else begin
					if (!wr_ff)
						rdata_o <= word_data_sync_i;
					flash_wr_n_o <= 1'b1;
					flash_oe_n_o <= 1'b1;
					cnt_ff       <= WH_CYC;
					state_ff     <= S_HOLD;
				end
			end
			S_HOLD: begin
				// data held past the write strobe's rising edge
				word_data_lines_oe_o <= 1'b0;
				if (cnt_ff > 4'h1) begin
					cnt_ff <= cnt_ff - 4'h1;
				end else begin
					flash_select_n_o <= 1'b1;
					done_o           <= 1'b1;
					state_ff         <= S_IDLE;
				end
			end
			default: state_ff <= S_IDLE;
			endcase
		end
	end
endmodule

// [verilog/bfci_host.v]
// bfci_host.v: host controller for a four-bank word-wide flash
// assumes: one flash on the pins, clocked by clk_i at 20 MHz; the user
//          issues one operation at a time and waits for done
//
// Function
// - bypass mode programs a word with two writes instead of four
// - during busy, bit 7 is complement polling, bit 6 toggles
// - separate select, write and output strobes avoid bus contention
`timescale 1ns/1ps
`include "bfci_map.vh"
module bfci_host #(
	parameter AW = `BFCI_ADDR_W,
	parameter DW = `BFCI_DATA_W,
	parameter PW = `BFCI_PAGE_W
) (
	// clock and reset
	input  wire          clk_i,
	input  wire          nrst_i,
	// user command port
	input  wire          req_i,
	input  wire [2:0]    op_i,
	input  wire [AW-1:0] addr_i,
	input  wire [DW-1:0] wdata_i,
	output wire          ready_o,
	output reg           done_o,
	output reg           fail_o,
	output reg  [DW-1:0] rdata_o,
	output reg           bypass_o,
	output reg           erase_busy_o,
	// flash pins
	output wire [AW-1:0] flash_addr_o,
	output wire          flash_select_n_o,
	output wire          flash_wr_n_o,
	output wire          flash_oe_n_o,
	output wire [DW-1:0] word_data_lines_o,
	output wire          word_data_lines_oe_o,
	input  wire [DW-1:0] word_data_lines_i
);
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_SEQ  = 4'h1;
	localparam [3:0] S_WAIT = 4'h2;
	localparam [3:0] S_POLL = 4'h3;
	localparam [3:0] S_PCHK = 4'h4;
	localparam [3:0] S_RD   = 4'h5;
	localparam [3:0] S_RDW  = 4'h6;
	localparam [3:0] S_DONE = 4'h7;
	localparam [2:0] MAXSEQ = 3'h6;

	reg  [3:0]    state_ff;
	reg  [2:0]    op_ff;
	reg  [AW-1:0] addr_ff;
	reg  [DW-1:0] wdata_ff;
	reg  [2:0]    idx_ff;
	reg  [2:0]    len_ff;
	reg  [DW-1:0] sync1_ff;
	reg  [DW-1:0] sync2_ff;
	reg           page_ok_ff;
	reg  [AW-PW-1:0] page_ff;
	reg  [DW-1:0] last_ff;
	reg           cyc_go;
	reg           cyc_wr;
	wire          cyc_done;
	wire [DW-1:0] cyc_rdata;
	wire          same_page;

	////////////////////////////////////////////////////////////////////
	// two flip-flop synchroniser on the asynchronous data lines
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_ff <= {DW{1'b0}};
			sync2_ff <= {DW{1'b0}};
		end else begin
			sync1_ff <= word_data_lines_i;
			sync2_ff <= sync1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////
	// page hit: upper address bits equal last read's page
	assign same_page = page_ok_ff && (addr_ff[AW-1:PW] == page_ff);
	assign ready_o   = (state_ff == S_IDLE);

	// command sequence table for the current operation and step
	reg [2:0] seq_len;
	always @* begin
		seq_len = 3'h1;
		case (op_ff)
		`BFCI_OP_PROG:   seq_len = bypass_o ? 3'h2 : 3'h4;
		`BFCI_OP_ERASE:  seq_len = MAXSEQ;
		`BFCI_OP_BYPON:  seq_len = 3'h3;
		`BFCI_OP_BYPOFF: seq_len = 3'h2;
		default:         seq_len = 3'h1;
		endcase
	end

	reg [AW-1:0] seq_addr;
	reg [DW-1:0] seq_data;
	always @* begin
		seq_addr = addr_ff;
		seq_data = wdata_ff;
		// unlock pair precedes every full sequence
		if (op_ff == `BFCI_OP_PROG && bypass_o) begin
			seq_data = (idx_ff == 3'h0) ? `BFCI_CMD_PROG : wdata_ff;
		end else if (op_ff == `BFCI_OP_PROG || op_ff == `BFCI_OP_ERASE ||
			op_ff == `BFCI_OP_BYPON) begin
			case (idx_ff)
			3'h0: begin
				seq_addr = `BFCI_UNLK_A1;
				seq_data = `BFCI_UNLK_D1;
			end
			3'h1: begin
				seq_addr = `BFCI_UNLK_A2;
				seq_data = `BFCI_UNLK_D2;
			end
			// second unlock pair is erase only; program puts its word here
			3'h3: begin
				if (op_ff == `BFCI_OP_ERASE) begin
					seq_addr = `BFCI_UNLK_A1;
					seq_data = `BFCI_UNLK_D1;
				end
			end
			3'h4: begin
				if (op_ff == `BFCI_OP_ERASE) begin
					seq_addr = `BFCI_UNLK_A2;
					seq_data = `BFCI_UNLK_D2;
				end
			end
			3'h2: begin
				seq_addr = `BFCI_UNLK_A1;
				if (op_ff == `BFCI_OP_PROG)
					seq_data = `BFCI_CMD_PROG;
				else if (op_ff == `BFCI_OP_ERASE)
					seq_data = `BFCI_CMD_ERASE;
				else
					seq_data = `BFCI_CMD_BYPASS;
			end
			default: begin
				if (op_ff == `BFCI_OP_ERASE)
					seq_data = `BFCI_CMD_SECT;
			end
			endcase
		end else if (op_ff == `BFCI_OP_BYPOFF) begin
			seq_data = (idx_ff == 3'h0) ? `BFCI_CMD_BYPRST :
				`BFCI_CMD_BYPRS2;
		end else if (op_ff == `BFCI_OP_SUSP) begin
			seq_data = `BFCI_CMD_SUSP;
		end else if (op_ff == `BFCI_OP_RESUME) begin
			seq_data = `BFCI_CMD_RESUME;
		end else begin
			seq_data = `BFCI_CMD_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////
	// cycle launch, one per state entry
	always @* begin
		cyc_go = 1'b0;
		cyc_wr = 1'b0;
		case (state_ff)
		S_SEQ: begin
			cyc_go = 1'b1;
			cyc_wr = 1'b1;
		end
		S_POLL, S_RD: cyc_go = 1'b1;
		default: cyc_go = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// operation sequencer
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_ff     <= S_IDLE;
			op_ff        <= `BFCI_OP_READ;
			addr_ff      <= {AW{1'b0}};
			wdata_ff     <= {DW{1'b0}};
			idx_ff       <= 3'h0;
			len_ff       <= 3'h0;
			page_ok_ff   <= 1'b0;
			page_ff      <= {(AW-PW){1'b0}};
			last_ff      <= {DW{1'b0}};
			done_o       <= 1'b0;
			fail_o       <= 1'b0;
			rdata_o      <= {DW{1'b0}};
			bypass_o     <= 1'b0;
			erase_busy_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_ff)
			S_IDLE: begin
				if (req_i) begin
					op_ff    <= op_i;
					addr_ff  <= addr_i;
					wdata_ff <= wdata_i;
					idx_ff   <= 3'h0;
					fail_o   <= 1'b0;
					state_ff <= (op_i == `BFCI_OP_READ) ? S_RD : S_SEQ;
				end
			end
			S_SEQ: begin
				len_ff   <= seq_len;
				state_ff <= S_WAIT;
				// writes may change the array; drop the page hit
				page_ok_ff <= 1'b0;
			end
			S_WAIT: begin
				if (cyc_done) begin
					if (idx_ff + 3'h1 < len_ff) begin
						idx_ff   <= idx_ff + 3'h1;
						state_ff <= S_SEQ;
					end else if (op_ff == `BFCI_OP_PROG ||
						op_ff == `BFCI_OP_ERASE) begin
						if (op_ff == `BFCI_OP_ERASE)
							erase_busy_o <= 1'b1;
						last_ff  <= {DW{1'b0}};
						idx_ff   <= 3'h0;
						state_ff <= S_POLL;
					end else begin
						if (op_ff == `BFCI_OP_BYPON)
							bypass_o <= 1'b1;
						if (op_ff == `BFCI_OP_BYPOFF ||
							op_ff == `BFCI_OP_RESET)
							bypass_o <= 1'b0;
						if (op_ff == `BFCI_OP_RESUME)
							erase_busy_o <= 1'b1;
						if (op_ff == `BFCI_OP_SUSP)
							erase_busy_o <= 1'b0;
						state_ff <= S_DONE;
					end
				end
			end
			S_POLL: state_ff <= S_PCHK;
			S_PCHK: begin
				if (cyc_done) begin
					last_ff <= cyc_rdata;
					// toggle bit steady across two reads means finished
					if (idx_ff != 3'h0 &&
						cyc_rdata[`BFCI_TOGGLE_BIT] ==
						last_ff[`BFCI_TOGGLE_BIT]) begin
						// final read word must match the whole written word
						fail_o <= (op_ff == `BFCI_OP_PROG) &&
							(cyc_rdata != wdata_ff);
						if (op_ff == `BFCI_OP_ERASE)
							erase_busy_o <= 1'b0;
						rdata_o  <= cyc_rdata;
						state_ff <= S_DONE;
					end else begin
						idx_ff   <= 3'h1;
						state_ff <= S_POLL;
					end
				end
			end
			S_RD: state_ff <= S_RDW;
			S_RDW: begin
				if (cyc_done) begin
					rdata_o    <= cyc_rdata;
					page_ok_ff <= 1'b1;
					page_ff    <= addr_ff[AW-1:PW];
					state_ff   <= S_DONE;
				end
			end
			S_DONE: begin
				done_o   <= 1'b1;
				state_ff <= S_IDLE;
			end
			default: state_ff <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin cycle engine
	bfci_cycle #(
		.AW (AW),
		.DW (DW)
	) u_cycle (
		.clk_i                (clk_i),
		.nrst_i               (nrst_i),
		.go_i                 (cyc_go),
		.wr_i                 (cyc_wr),
		.fast_i               (same_page),
		.addr_i               (cyc_wr ? seq_addr : addr_ff),
		.wdata_i              (seq_data),
		.busy_o               (),
		.done_o               (cyc_done),
		.rdata_o              (cyc_rdata),
		.flash_addr_o         (flash_addr_o),
		.flash_select_n_o     (flash_select_n_o),
		.flash_wr_n_o         (flash_wr_n_o),
		.flash_oe_n_o         (flash_oe_n_o),
		.word_data_lines_o    (word_data_lines_o),
		.word_data_lines_oe_o (word_data_lines_oe_o),
		.word_data_sync_i     (sync2_ff)
	);
endmodule

// [sim/bfci_host_sva.sv]
// bfci_host_sva.sv: pin and handshake checks on the flash host controller
// assumes: bound into bfci_host; one clock, async active-low reset
`timescale 1ns/1ps
module bfci_host_sva (
	// clock, reset and user side
	input wire        clk_i,
	input wire        nrst_i,
	input wire        req_i,
	input wire [2:0]  op_i,
	input wire        ready_o,
	input wire        done_o,
	input wire        bypass_o,
	input wire        erase_busy_o,
	// flash pins
	input wire        flash_select_n_o,
	input wire        flash_wr_n_o,
	input wire        flash_oe_n_o,
	input wire [15:0] word_data_lines_o,
	input wire        word_data_lines_oe_o
);
////////////////////////////////////////////////////////////////////////
default clocking @(posedge clk_i); endclocking
default disable iff (!nrst_i);
reg [2:0] op_ff;
reg [2:0] nw_ff;
reg       wr_q_ff;
// op taken and write pulses since; counts restart at each request
always @(posedge clk_i or negedge nrst_i) begin
	if (!nrst_i) begin
		op_ff   <= 3'h0;
		nw_ff   <= 3'h0;
		wr_q_ff <= 1'b1;
	end else begin
		wr_q_ff <= flash_wr_n_o;
		if (req_i && ready_o) begin
			op_ff <= op_i;
			nw_ff <= 3'h0;
		end else if (wr_q_ff && !flash_wr_n_o)
			nw_ff <= nw_ff + 3'h1;
	end
end
////////////////////////////////////////////////////////////////////////
chk_strobe_excl: assert property (!flash_wr_n_o |-> flash_oe_n_o)
	else $error("write and output strobes low together");
chk_no_clash: assert property (!flash_oe_n_o |-> !word_data_lines_oe_o)
	else $error("host drives data while flash outputs");
chk_wr_latch: assert property ($fell(flash_wr_n_o) |->
	!flash_select_n_o && word_data_lines_oe_o ##1
	flash_wr_n_o && $stable(word_data_lines_o))
	else $error("write pulse malformed");
chk_done_pulse: assert property (done_o |=> !done_o && ready_o)
	else $error("done not a single pulse");
chk_idle_quiet: assert property (ready_o |-> flash_select_n_o &&
	flash_wr_n_o && flash_oe_n_o)
	else $error("flash selected while idle");
chk_prog_writes: assert property (done_o && op_ff == 3'h1 |->
	nw_ff == (bypass_o ? 3'h2 : 3'h4))
	else $error("wrong write count for program");
chk_bypass_mode: assert property (done_o && (op_ff == 3'h5 ||
	op_ff == 3'h6 || op_ff == 3'h7) |-> bypass_o == (op_ff == 3'h5))
	else $error("bypass flag wrong");
chk_susp_flag: assert property (done_o && op_ff == 3'h3 |=>
	!erase_busy_o)
	else $error("erase flag still set after suspend");
endmodule
bind bfci_host bfci_host_sva i_bfci_host_sva (
	.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i), .op_i(op_i),
	.ready_o(ready_o), .done_o(done_o), .bypass_o(bypass_o),
	.erase_busy_o(erase_busy_o), .flash_select_n_o(flash_select_n_o),
	.flash_wr_n_o(flash_wr_n_o), .flash_oe_n_o(flash_oe_n_o),
	.word_data_lines_o(word_data_lines_o),
	.word_data_lines_oe_o(word_data_lines_oe_o)
);

// [sim/bfci_flash_model.sv]
// bfci_flash_model.sv: behavioural four-bank word flash for the bench
// assumes: pins come from the controller; access times not modelled
`timescale 1ns/1ps
module bfci_flash_model #(
	parameter       BUSY = 3,
	parameter [7:0] PROT = 8'h7f
) (
	// pins from the host
	input  wire [22:0] addr_i,
	input  wire        sel_n_i,
	input  wire        wr_n_i,
	input  wire        oe_n_i,
	input  wire [15:0] dat_i,
	// data put out by the flash
	output wire [15:0] dat_o
);
////////////////////////////////////////////////////////////////////////
reg [15:0] mem [int];  // sparse; unwritten words read erased
reg [15:0] q = 16'h0;
reg [22:0] pa = 23'h0;
reg [15:0] pd = 16'h0;
integer    pb = 0;
integer    eb = 0;
integer    n = 0;
reg        pc = 0, by = 0, er = 0, su = 0, tg = 0;
function [15:0] rd(input [22:0] a);
	rd = mem.exists(a) ? mem[a] : 16'hffff;
endfunction
// outer banks hold 1 Mw, middle banks 3 Mw
function [1:0] bk(input [22:0] a);
	bk = a < 23'h100000 ? 2'h0 : a < 23'h400000 ? 2'h1 :
		a < 23'h700000 ? 2'h2 : 2'h3;
endfunction
////////////////////////////////////////////////////////////////////////
// command decode on the rising write strobe
always @(posedge wr_n_i) begin
	if (!sel_n_i) begin
		if (dat_i == 16'h00f0 || pb > 0)
			n = 0;  // writes ignored while programming
		else if (pc) begin
			pc = 0;
			pa = addr_i;
			pd = dat_i;
			pb = BUSY;
			if (addr_i[22:15] != PROT)
				mem[addr_i] = rd(addr_i) & dat_i;
		end else if (eb > 0 && !su)
			su = (dat_i == 16'h00b0);
		else if (su && dat_i == 16'h0030)
			su = 0;
		else if (by) begin  // two-write program
			pc = (dat_i == 16'h00a0);
			by = (dat_i != 16'h0090);
		end else if (n == 0)
			n = (addr_i == 23'h555 && dat_i == 16'h00aa) ? 1 : 0;
		else if (n == 1)
			n = (addr_i == 23'h2aa && dat_i == 16'h0055) ? 2 : 0;
		else begin
			n = 0;
			pc = (dat_i == 16'h00a0);
			by = (dat_i == 16'h0020);
			if (er && dat_i == 16'h0030) begin
				eb = BUSY;
				pa = addr_i;
				foreach (mem[k])
					if (k[22:15] == addr_i[22:15] && addr_i[22:15] != PROT)
						mem[k] = 16'hffff;
			end
			er = (dat_i == 16'h0080);
		end
	end
end
// a read in the busy bank gets status, other banks get array data
always @(negedge oe_n_i) begin
	if (!sel_n_i) begin
		if ((pb > 0 || (eb > 0 && !su)) && bk(addr_i) == bk(pa)) begin
			q = {8'h00, pb > 0 ? ~pd[7] : 1'b0, tg, 6'h00};
			tg = ~tg;
			if (pb > 0)
				pb = pb - 1;
			else
				eb = eb - 1;
		end else
			q = rd(addr_i);
	end
end
// released lines show the inverse, never a stale match
assign dat_o = (!sel_n_i && !oe_n_i) ? q : ~q;
endmodule

// [sim/bfci_host_bench.sv]
// bfci_host_bench.sv: self-checking bench for the flash host controller
// assumes: flash model on the pins, checker bound into the controller
`timescale 1ns/1ps
module bfci_host_bench;
reg         clk_i = 1'b0;
reg         nrst_i = 1'b0;
reg         req_i = 1'b0;
reg  [2:0]  op_i = 3'h0;
reg  [22:0] addr_i = 23'h0;
reg  [15:0] wdata_i = 16'h0;
wire        ready_o, done_o, fail_o, bypass_o, erase_busy_o;
wire [15:0] rdata_o, h_dq, m_dq, dq_wire;
wire [22:0] f_addr;
wire        f_sel_n, f_wr_n, f_oe_n, h_dq_oe;
integer     fails = 0;
integer     total_checks = 0;
integer     cyc = 0;
////////////////////////////////////////////////////////////////////////
always #25 clk_i = ~clk_i;
// shared data wire: host drives only with its enable up
assign dq_wire = h_dq_oe ? h_dq : m_dq;
bfci_host i_bfci_host (
	.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i), .op_i(op_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o),
	.done_o(done_o), .fail_o(fail_o), .rdata_o(rdata_o),
	.bypass_o(bypass_o), .erase_busy_o(erase_busy_o),
	.flash_addr_o(f_addr), .flash_select_n_o(f_sel_n),
	.flash_wr_n_o(f_wr_n), .flash_oe_n_o(f_oe_n),
	.word_data_lines_o(h_dq), .word_data_lines_oe_o(h_dq_oe),
	.word_data_lines_i(dq_wire)
);
bfci_flash_model i_bfci_flash_model (
	.addr_i(f_addr), .sel_n_i(f_sel_n), .wr_n_i(f_wr_n),
	.oe_n_i(f_oe_n), .dat_i(dq_wire), .dat_o(m_dq)
);
////////////////////////////////////////////////////////////////////////
task close_out;
	begin
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
endtask
task chk(input string nm, input [15:0] e, input [15:0] g);
	begin
		total_checks = total_checks + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	end
endtask
// one user operation: request for one cycle, wait for done
task run(input [2:0] op, input [22:0] a, input [15:0] d);
	integer w;
	begin
		@(negedge clk_i);
		req_i = 1'b1;
		op_i = op;
		addr_i = a;
		wdata_i = d;
		@(negedge clk_i);
		req_i = 1'b0;
		w = 0;
		while (done_o !== 1'b1 && w < 2000) begin
			@(negedge clk_i);
			w = w + 1;
		end
		chk("done", 16'h1, {15'h0, done_o});
	end
endtask
task rdw(input [22:0] a, input [15:0] e);
	begin
		run(3'h0, a, 16'h0);
		chk("rdata", e, rdata_o);
	end
endtask
////////////////////////////////////////////////////////////////////////
// program, read back, then another word of the same page
task t_prog;
	begin
		run(3'h1, 23'h000010, 16'h1234);
		chk("fail", 16'h0, {15'h0, fail_o});
		rdw(23'h000010, 16'h1234);
		rdw(23'h000011, 16'hffff);
	end
endtask
// fast program; poll bit of data a5c3 starts complemented
task t_bypass;
	begin
		run(3'h5, 23'h0, 16'h0);
		chk("bypass", 16'h1, {15'h0, bypass_o});
		run(3'h1, 23'h0c0020, 16'ha5c3);
		rdw(23'h0c0020, 16'ha5c3);
		run(3'h6, 23'h0, 16'h0);
		chk("bypass", 16'h0, {15'h0, bypass_o});
	end
endtask
// the model's protected sector refuses the program
task t_prot;
	begin
		run(3'h1, 23'h3f8004, 16'h0000);
		chk("fail", 16'h1, {15'h0, fail_o});
		rdw(23'h3f8004, 16'hffff);
	end
endtask
// erase one sector, the neighbour keeps its data
task t_erase;
	begin
		run(3'h1, 23'h408000, 16'h0f0f);
		run(3'h1, 23'h410000, 16'h5555);
		run(3'h2, 23'h408000, 16'h0);
		rdw(23'h408000, 16'hffff);
		rdw(23'h410000, 16'h5555);
	end
endtask
// single-write commands leave the array readable
task t_misc;
	begin
		run(3'h4, 23'h408000, 16'h0);
		chk("erase busy", 16'h1, {15'h0, erase_busy_o});
		run(3'h3, 23'h408000, 16'h0);
		chk("erase busy", 16'h0, {15'h0, erase_busy_o});
		run(3'h7, 23'h0, 16'h0);
		rdw(23'h000010, 16'h1234);
	end
endtask
////////////////////////////////////////////////////////////////////////
// hang guard, far above the under one thousand cycles needed
always @(posedge clk_i) begin
	cyc = cyc + 1;
	if (cyc == 20000) begin
		fails = fails + 1;
		close_out;
	end
end
initial begin
	repeat (4) @(negedge clk_i);
	nrst_i = 1'b1;
	t_prog;
	t_bypass;
	t_prot;
	t_erase;
	t_misc;
	close_out;
end
endmodule
